// File: pkg/ghp_pkg.sv
// Constants for the general-purpose 16-bit host port.
// Assumes a single core clock; all widths and strap codes live here.
package ghp_pkg;
    // =====================================================================
    // Widths
    localparam int GHP_DATA_W = 16;
    localparam int GHP_ADDR_W = 17;
    localparam int GHP_BYTE_W = 8;
    // =====================================================================
    // Strap codes
    localparam logic [2:0] GHP_IFACE_GENERIC = 3'h7;
    localparam logic GHP_BUS_STATUS_GENERIC = 1'h1;
    localparam logic GHP_ORDER_LITTLE = 1'h0;
    localparam logic GHP_ORDER_BIG = 1'h1;
    // =====================================================================
    // Reset values, timing and store size
    localparam logic [15:0] GHP_DATA_RESET = 16'h0000;
    localparam int GHP_SYNC_STAGES = 2;
    localparam int GHP_MEM_WORDS = 64;
    localparam int GHP_MEM_AW = 6;
    // Port state machine.
    typedef enum logic [2:0] {
        GHP_IDLE = 3'b000,
        GHP_REQ = 3'b001,
        GHP_DONE = 3'b010,
        GHP_HOLD = 3'b011
    } ghp_state_e;
endpackage

// File: verilog/ghp_mem.sv
// Small word store standing in for the display buffer behind the port.
// Assumes requests are synchronous to CLK; read data come from a register.
`timescale 1ns/1ps
module ghp_mem
    import ghp_pkg::*;
(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [1:0] wr_lane,
    input wire logic [GHP_MEM_AW-1:0] addr,
    input wire logic [GHP_DATA_W-1:0] wr_data,
    output logic [GHP_DATA_W-1:0] rd_data
);
    logic [GHP_DATA_W-1:0] mem [GHP_MEM_WORDS];

    // =====================================================================
    // Byte-lane writes and a registered read.
    always_ff @(posedge clk) begin
        if (wr_en && wr_lane[0]) begin
            mem[addr][7:0] <= wr_data[7:0];
        end
        if (wr_en && wr_lane[1]) begin
            mem[addr][15:8] <= wr_data[15:8];
        end
        rd_data <= mem[addr];
    end
endmodule

// File: verilog/ghp_port.sv
// Host-side port of the display controller, general-purpose 16-bit mode.
// Assumes all host pins and the host bus clock arrive asynchronously to CLK.
//
// Summary of operation
// RL1: Transfers run at host bus clock edges.
// RL2: Sixteen data lines, seventeen address inputs.
// RL3: Host decodes high address into chip select.
// RL4: Host places address, then lowers select.
// RL5: Host lowers write strobe only when writing.
// RL6: Host lowers read strobe only when reading.
// RL7: High-byte enable qualifies upper byte both ways; the port uses it on writes only, and reads return the whole word.
// RL8: Host: enable low 16-bit, high 8-bit.
// RL9: Wait released when data valid or accepted.
// RL10: Wait held until arbitration grants host.
// RL11: Ready low inserts wait; host extends cycle.
// RL12: Status and direction inputs ignored during cycles.
// RL13: Endian strap selects data byte order.
// RL14: Straps latched at reset release fix mode.
// RL15: Straps 111 with status high select mode.
// RL16: Strap zero little endian, one big endian.
// RL17: Drive data only during select and read.
`timescale 1ns/1ps
module ghp_port
    import ghp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic HOST_BUS_CLOCK,
    input wire logic DISPLAY_CTRL_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic UPPER_BYTE_ENABLE_N,
    input wire logic PORT_ADDR_LSB,
    input wire logic [15:1] PORT_ADDR_HI,
    input wire logic PORT_ADDR_TOP,
    input wire logic [GHP_DATA_W-1:0] PORT_DATA_IN,
    output logic [GHP_DATA_W-1:0] PORT_DATA_OUT,
    output logic PORT_DATA_OE_N,
    output logic DISPLAY_CTRL_READY,
    input wire logic BUS_STATUS_STRAP,
    input wire logic READ_WRITE_DIR,
    input wire logic IFACE_SELECT_STRAP0,
    input wire logic IFACE_SELECT_STRAP1,
    input wire logic IFACE_SELECT_STRAP2,
    input wire logic BYTE_ORDER_STRAP,
    input wire logic REFRESH_BUSY,
    output logic HOST_GRANT,
    output logic MODE_ACTIVE,
    output logic BIG_ENDIAN
);
    ghp_state_e state;
    logic [GHP_SYNC_STAGES-1:0] clk_s, cs_s, rd_s, wr_s;
    logic bclk_d;
    logic rst_d;
    logic [2:0] iface_lat;
    logic bs_lat;
    logic [GHP_ADDR_W-1:0] addr_s1, addr_s2;
    logic [GHP_DATA_W-1:0] din_s1, din_s2;
    logic ube_s1, ube_s2, lsb_s1, lsb_s2;
    logic is_write;
    logic mem_wr;
    logic [1:0] mem_lane;
    logic [GHP_DATA_W-1:0] mem_rd;
    logic [GHP_DATA_W-1:0] mem_wd;
    logic bclk_rise;
    logic cyc_active;
    logic [4:0] strap_s1, strap_s2;
    logic [1:0] host_lane;

    // Swap bytes for big-endian hosts; used on both write and read paths.
    function automatic logic [GHP_DATA_W-1:0] order_bytes(
        input logic [GHP_DATA_W-1:0] d,
        input logic big
    );
        order_bytes = big ? {d[GHP_BYTE_W-1:0], d[GHP_DATA_W-1:GHP_BYTE_W]} : d;
    endfunction

    // =====================================================================
    // Two-stage synchronisers; only the second stage is read by logic.
    always_ff @(posedge CLK) begin
        clk_s <= {clk_s[0], HOST_BUS_CLOCK};
        cs_s <= {cs_s[0], DISPLAY_CTRL_SELECT_N};
        rd_s <= {rd_s[0], READ_STROBE_N};
        wr_s <= {wr_s[0], WRITE_STROBE_N};
        addr_s1 <= {PORT_ADDR_TOP, PORT_ADDR_HI, PORT_ADDR_LSB};
        addr_s2 <= addr_s1;
        din_s1 <= PORT_DATA_IN;
        din_s2 <= din_s1;
        ube_s1 <= UPPER_BYTE_ENABLE_N;
        ube_s2 <= ube_s1;
        lsb_s1 <= PORT_ADDR_LSB;
        lsb_s2 <= lsb_s1;
        bclk_d <= clk_s[1];
    end

    // Host transfers start only on rising host bus clock edges.
    assign bclk_rise = clk_s[1] && !bclk_d; // RL1

    // Strap pins are board levels, but they still pass two flops first so that a
    // strap still settling at power-up cannot make the latch metastable.
    always_ff @(posedge CLK) begin
        strap_s1 <= {BYTE_ORDER_STRAP, BUS_STATUS_STRAP, IFACE_SELECT_STRAP2,
                     IFACE_SELECT_STRAP1, IFACE_SELECT_STRAP0};
        strap_s2 <= strap_s1;
    end

    // =====================================================================
    // Straps are caught at the first edge after reset falls, never inside reset.
    always_ff @(posedge CLK) begin
        rst_d <= RST;
        if (RST) begin
            iface_lat <= 3'h0;
            bs_lat <= 1'h0;
            BIG_ENDIAN <= GHP_ORDER_LITTLE;
        end else if (rst_d) begin
            iface_lat <= strap_s2[2:0]; // RL14
            bs_lat <= strap_s2[3]; // RL14
            BIG_ENDIAN <= strap_s2[4] ? GHP_ORDER_BIG : GHP_ORDER_LITTLE; // RL16
        end
    end

    // The direction input plays no part in this mode; status only at strap time.
    assign MODE_ACTIVE = (iface_lat == GHP_IFACE_GENERIC) &&
                         (bs_lat == GHP_BUS_STATUS_GENERIC); // RL15 RL12

    // A cycle is open while select and a strobe are low. Both strobes low is not a legal
    // host cycle; it is taken as a write, since the write strobe wins below.
    assign cyc_active = MODE_ACTIVE && !cs_s[1] && (!rd_s[1] || !wr_s[1]);

    // =====================================================================
    // Transfer sequencer: request, wait for grant, complete, hold to end.
    // A refresh that never ends stalls the host too; its bus timeout must cover that.
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= GHP_IDLE;
            is_write <= 1'h0;
        end else begin
            unique case (state)
                GHP_IDLE: begin
                    if (cyc_active && bclk_rise) begin
                        state <= GHP_REQ;
                        is_write <= !wr_s[1];
                    end
                end
                GHP_REQ: begin
                    if (!REFRESH_BUSY) begin // RL10
                        state <= GHP_DONE;
                    end
                end
                GHP_DONE: begin
                    state <= GHP_HOLD;
                end
                GHP_HOLD: begin
                    if (!cyc_active) begin
                        state <= GHP_IDLE;
                    end
                end
                default: begin
                    state <= GHP_IDLE;
                end
            endcase
        end
    end

    // Grant is the one core clock in which the store belongs to the host.
    assign HOST_GRANT = (state == GHP_REQ) && !REFRESH_BUSY;

    // Lanes as the host sees them: its upper byte when the enable is low or the odd
    // byte is addressed, its lower byte only at an even address. A big-endian host's
    // bytes sit swapped in the store, so the lane pair swaps with the data.
    always_comb begin
        host_lane[1] = !ube_s2 || lsb_s2; // RL7
        host_lane[0] = !lsb_s2; // RL7
        mem_lane = BIG_ENDIAN ? {host_lane[0], host_lane[1]} : host_lane; // RL13
    end
    // Writes land in the grant cycle itself, so data are accepted before ready rises.
    assign mem_wr = HOST_GRANT && is_write;
    assign mem_wd = order_bytes(din_s2, BIG_ENDIAN); // RL13

    ghp_mem u_mem (
        .clk(CLK),
        .wr_en(mem_wr),
        .wr_lane(mem_lane),
        .addr(addr_s2[GHP_MEM_AW:1]), // RL2
        .wr_data(mem_wd),
        .rd_data(mem_rd)
    );

    // =====================================================================
    // Read data is captured when the store answers and held for the cycle.
    // It stays until the next read, so a late host sample still sees the right word.
    always_ff @(posedge CLK) begin
        if (RST) begin
            PORT_DATA_OUT <= GHP_DATA_RESET;
        end else if (state == GHP_DONE && !is_write) begin
            PORT_DATA_OUT <= order_bytes(mem_rd, BIG_ENDIAN); // RL13
        end
    end

    // Ready stays low from cycle start until data valid or accepted.
    // It is a flop so that the host never sees a glitch while the state machine moves.
    always_ff @(posedge CLK) begin
        if (RST) begin
            DISPLAY_CTRL_READY <= 1'h1;
        end else if (state == GHP_HOLD) begin
            DISPLAY_CTRL_READY <= 1'h1; // RL9
        end else if (cyc_active) begin
            DISPLAY_CTRL_READY <= 1'h0; // RL11
        end else begin
            DISPLAY_CTRL_READY <= 1'h1;
        end
    end

    // Bus driven only while select and read are low; enable is active low.
    // The enable trails the pins by the synchroniser, so the bus turns round a few core
    // clocks after the read strobe rises; the host must allow that before driving.
    always_ff @(posedge CLK) begin
        if (RST) begin
            PORT_DATA_OE_N <= 1'h1;
        end else begin
            PORT_DATA_OE_N <= !(MODE_ACTIVE && !cs_s[1] && !rd_s[1]); // RL17
        end
    end
endmodule

// File: tb/ghp_port_assertions.sv
// Timing checker for the host port, watching its top pins.
// Bound to ghp_port below; one core clock domain.
`timescale 1ns/1ps
module ghp_port_assertions (
    input wire logic CLK,
    input wire logic RST,
    input wire logic DISPLAY_CTRL_READY,
    input wire logic PORT_DATA_OE_N,
    input wire logic [15:0] PORT_DATA_OUT,
    input wire logic REFRESH_BUSY,
    input wire logic HOST_GRANT,
    input wire logic MODE_ACTIVE,
    input wire logic BIG_ENDIAN
);
    // ==========
    // Strap outputs may settle an edge late, so the mode check looks back two cycles and the order check three.
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Core clocks of wait while the store is free; a refresh clears the count.
    // The bound covers one whole host clock of 25 core clocks plus the pipeline.
    logic [5:0] wait_run;
    always_ff @(posedge CLK) begin
        if (RST || DISPLAY_CTRL_READY || REFRESH_BUSY) begin
            wait_run <= 6'h00;
        end else if (wait_run != 6'h3f) begin
            wait_run <= wait_run + 6'h01;
        end
    end
    a_reset_quiet: assert property (disable iff (1'b0)
        RST |=> DISPLAY_CTRL_READY && PORT_DATA_OE_N) else $error("reset");
    a_unmoded_idle: assert property (
        !MODE_ACTIVE |-> DISPLAY_CTRL_READY && PORT_DATA_OE_N) else $error("unmoded");
    a_mode_kept: assert property (
        !$past(RST, 2) && !$past(RST) |-> $stable(MODE_ACTIVE)) else $error("mode");
    a_order_kept: assert property (
        !$past(RST, 3) && !$past(RST, 2) && !$past(RST) |-> $stable(BIG_ENDIAN))
        else $error("order");
    a_grant_free: assert property (
        HOST_GRANT |-> !REFRESH_BUSY ##3 DISPLAY_CTRL_READY) else $error("grant");
    a_wait_busy: assert property (
        (REFRESH_BUSY && !DISPLAY_CTRL_READY) [*5] |=> !DISPLAY_CTRL_READY) else $error("busy");
    a_wait_ends: assert property (
        wait_run < 6'h28) else $error("wait");
    a_data_stands: assert property (
        DISPLAY_CTRL_READY && !PORT_DATA_OE_N && $past(DISPLAY_CTRL_READY && !PORT_DATA_OE_N)
        |-> $stable(PORT_DATA_OUT)) else $error("data");
endmodule

bind ghp_port ghp_port_assertions chk (.CLK(CLK), .RST(RST),
    .DISPLAY_CTRL_READY(DISPLAY_CTRL_READY), .PORT_DATA_OE_N(PORT_DATA_OE_N),
    .PORT_DATA_OUT(PORT_DATA_OUT), .REFRESH_BUSY(REFRESH_BUSY), .HOST_GRANT(HOST_GRANT),
    .MODE_ACTIVE(MODE_ACTIVE), .BIG_ENDIAN(BIG_ENDIAN));

// File: tb/ghp_host_model.sv
// Host processor bus model for the port.
// Expects the core clock; ready is sampled on its rising edge.
`timescale 1ns/1ps
module ghp_host_model (
    input wire logic clk,
    input wire logic ready,
    input wire logic [15:0] rd_data,
    input wire logic oe_n,
    output logic sel_n,
    output logic rd_n,
    output logic wr_n,
    output logic ube_n,
    output logic lsb,
    output logic [5:0] waddr,
    output logic [15:0] wr_data
);
    // ==========
    // Idle bus from time zero.
    initial begin
        {sel_n, rd_n, wr_n, ube_n, lsb, waddr, wr_data} = 27'h7c00000;
    end
    // One transfer; address first, then select, stretched while ready is low.
    task automatic xfer(input logic [35:0] r, output logic [15:0] q);
        @(negedge clk);
        {ube_n, lsb, waddr, wr_data} = {r[28], r[24], r[21:16], r[15:0]};
        @(negedge clk);
        sel_n = 1'b0;
        rd_n = r[32];
        wr_n = !r[32];
        while (ready === 1'b1) @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        // A bus that the port leaves undriven reads back inverted, so a missing enable shows.
        q = oe_n ? ~rd_data : rd_data;
        @(negedge clk);
        {sel_n, rd_n, wr_n} = 3'h7;
        // Released data shows its inverse, never the stale value.
        wr_data = ~wr_data;
    endtask
endmodule

// File: tb/ghp_port_tb.sv
// Self-checking bench for the host port.
// The host model drives the bus; straps and refresh are driven here.
`timescale 1ns/1ps
module ghp_port_tb
    import ghp_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hclk = 1'b0;
    logic busy = 1'b0;
    logic bs = 1'b1;
    logic big = 1'b0;
    logic [2:0] cfg = 3'h7;
    logic rdy, oe_n, grant, mode, endian, sel_n, rd_n, wr_n, ube_n, lsb;
    logic [5:0] wa;
    logic [15:0] wd, dout, q;
    int errors = 0;
    int check_count = 0;
    // Rows: write, high byte off, address bit 0, word address, data or read value.
    logic [35:0] rows [11] = '{36'h10001a5c3, 36'h00001a5c3, 36'h11001ff11, 36'h00001a511,
        36'h1110122ee, 36'h000012211, 36'h1010177aa, 36'h000017711, 36'h1003f0f0f,
        36'h0003f0f0f, 36'h000017711};
    // Host clock edges are kept off the core clock grid.
    always #2.5 clk = ~clk;
    always begin
        #1.1;
        hclk = ~hclk;
        #61.4;
    end
    ghp_port dut (.CLK(clk), .RST(rst), .HOST_BUS_CLOCK(hclk), .DISPLAY_CTRL_SELECT_N(sel_n),
        .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .UPPER_BYTE_ENABLE_N(ube_n),
        .PORT_ADDR_LSB(lsb), .PORT_ADDR_HI({9'h000, wa}), .PORT_ADDR_TOP(1'b0),
        .PORT_DATA_IN(wd), .PORT_DATA_OUT(dout), .PORT_DATA_OE_N(oe_n),
        .DISPLAY_CTRL_READY(rdy), .BUS_STATUS_STRAP(bs), .READ_WRITE_DIR(bs),
        .IFACE_SELECT_STRAP0(cfg[0]), .IFACE_SELECT_STRAP1(cfg[1]),
        .IFACE_SELECT_STRAP2(cfg[2]), .BYTE_ORDER_STRAP(big), .REFRESH_BUSY(busy),
        .HOST_GRANT(grant), .MODE_ACTIVE(mode), .BIG_ENDIAN(endian));
    ghp_host_model host (.clk(clk), .ready(rdy), .rd_data(dout), .oe_n(oe_n), .sel_n(sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .ube_n(ube_n), .lsb(lsb), .waddr(wa), .wr_data(wd));
    // ==========
    // Compare and verdict.
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset with given straps, then move them to show they were captured.
    task automatic do_reset(input logic [2:0] c, input logic s, input logic b);
        @(negedge clk);
        {cfg, bs, big, rst} = {c, s, b, 1'b1};
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        {cfg, bs, big} = ~{c, s, b};
        @(negedge clk);
        check("mode", 16'(c == GHP_IFACE_GENERIC && s), 16'(mode));
        check("order", 16'(b), 16'(endian));
    endtask
    // ==========
    // Table rows, then refresh hold, byte swap and unselected modes.
    initial begin
        do_reset(3'h7, 1'b1, 1'b0);
        foreach (rows[i]) begin
            host.xfer(rows[i], q);
            if (!rows[i][32]) check("read", rows[i][15:0], q);
        end
        busy = 1'b1;
        fork
            host.xfer(36'h000017711, q);
            begin
                repeat (60) @(negedge clk);
                check("wait", 16'h0000, 16'(rdy));
                check("grant", 16'h0000, 16'(grant));
                busy = 1'b0;
            end
        join
        check("held", 16'h7711, q);
        do_reset(3'h7, 1'b1, 1'b1);
        host.xfer(36'h000017711, q);
        check("swap", 16'h1177, q);
        // A byte on the host's upper lane must come back on that lane in big-endian order.
        host.xfer(36'h1110122ee, q);
        host.xfer(36'h000017711, q);
        check("swap byte", 16'h2277, q);
        for (int k = 0; k < 2; k++) begin
            do_reset({2'h3, ~k[0]}, k[0], 1'b0);
            {host.sel_n, host.rd_n} = 2'h0;
            repeat (60) @(negedge clk);
            check("unmoded", 16'h0001, 16'({rdy, oe_n} == 2'h3));
            {host.sel_n, host.rd_n} = 2'h3;
        end
        finish_test();
    end
    // Watchdog well beyond the few thousand nanoseconds the run needs.
    initial begin
        #50000;
        errors++;
        finish_test();
    end
endmodule
